// [core/rgh_core.sv]
// Purpose: Gain hold control, demodulator scaling, detector DAC source and level path.
// Assumes: Datapath inputs are synchronous to i_sys_clk; gain arithmetic is outside.
// Notes: Registers reached over APB; unmapped addresses answer pslverr.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module rgh_core (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic i_gain_hold_pin,
  input wire logic i_second_squelch_output,
  output logic o_gain_hold_pin_out,
  output logic o_gain_hold_pin_oe,
  input wire logic i_fir_tick,
  input wire logic [7:0] i_bb_power,
  input wire logic [7:0] i_chan_power_log,
  input wire logic [5:0] i_calc_gain,
  input wire logic i_calc_wsel,
  input wire logic i_att_active,
  input wire logic i_demod_vld,
  input wire logic [23:0] i_demod,
  input wire logic [23:0] i_filter_out,
  output logic [5:0] o_pga_gain,
  output logic [15:0] o_filter_word,
  output logic [7:0] o_judge_power,
  output logic [11:0] o_detector_dac,
  output logic o_rx_frame,
  output logic o_rx_bit_clk,
  output logic o_rx_serial_data_pin
);
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_DETECT} rgh_st_t;

  rgh_pkg::rgh_ctrl_t ctrl_q;
  rgh_pkg::rgh_lvl_t lvl_q;
  rgh_pkg::rgh_gain_t cur_q;
  rgh_pkg::rgh_gain_t pend_q;
  rgh_st_t st_q;
  logic [7:0] time_q;
  logic [23:0] dcof_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic hold_prev_q;
  logic hold;
  logic hold_rise;
  logic hold_fall;
  logic released_q;
  logic [3:0] cnt_q;
  logic measure;
  logic [7:0] meas_q;
  logic [7:0] bb_rb_q;
  logic [14:0] acc_q;
  logic [6:0] nsmp_q;
  logic [7:0] avg_q;
  logic [7:0] level_q;
  logic [15:0] demod16_q;
  logic [11:0] dac_q;
  logic [23:0] shift_q;
  logic [4:0] bit_q;
  logic sclk_q;
  logic frame_q;
  logic ld_pend_q;
  logic acc;
  logic wr;
  logic [23:0] dsum;
  logic [7:0] nlim;
  logic signed [10:0] lvl_s;
  logic [7:0] level_d;
  logic [12:0] ldac;
  logic [12:0] lfloor;

  // APB access phase; the slave always answers without wait states.
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign pready = 1'b1;

  // Register writes.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= rgh_pkg::RGH_CTRL_RST;
      time_q <= rgh_pkg::RGH_TIME_RST;
      dcof_q <= 24'h00_0000;
      lvl_q <= 32'h0000_0000;
    end else if (wr) begin
      if (paddr == rgh_pkg::RGH_A_CTRL) begin
        ctrl_q <= pwdata;
      end else if (paddr == rgh_pkg::RGH_A_TIME) begin
        time_q <= pwdata[7:0];
      end else if (paddr == rgh_pkg::RGH_A_DCOF) begin
        dcof_q <= pwdata[23:0];
      end else if (paddr == rgh_pkg::RGH_A_LVL) begin
        lvl_q <= pwdata;
      end
    end
  end

  // Read mux and error answer for unmapped addresses.
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == rgh_pkg::RGH_A_CTRL) begin
      prdata = ctrl_q;
    end else if (paddr == rgh_pkg::RGH_A_TIME) begin
      prdata = {24'h00_0000, time_q};
    end else if (paddr == rgh_pkg::RGH_A_DCOF) begin
      prdata = {8'h00, dcof_q};
    end else if (paddr == rgh_pkg::RGH_A_LVL) begin
      prdata = lvl_q;
    end else if (paddr == rgh_pkg::RGH_A_STAT) begin
      prdata = {8'h00, hold, cur_q.wsel, cur_q.gain, bb_rb_q, level_q};
    end else begin
      pslverr = acc;
    end
  end

  // Shared pin: squelch output by default, hold input when selected.
  assign o_gain_hold_pin_out = i_second_squelch_output;
  assign o_gain_hold_pin_oe = ctrl_q.hold_source_select;

  // Two-stage synchroniser on the hold pin.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= i_gain_hold_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Hold is the request bit or the synchronised pin when pin control is on.
  assign hold = ctrl_q.hold_request_bit | (ctrl_q.hold_source_select & pin_s2_q);
  assign hold_rise = hold & ~hold_prev_q;
  assign hold_fall = ~hold & hold_prev_q;

  // Edge history and the first-release marker of mode 1.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      hold_prev_q <= 1'b0;
      released_q <= 1'b0;
    end else begin
      hold_prev_q <= hold;
      // The marker only has meaning in mode 1; leaving it set in mode 0 would defer updates.
      if (!ctrl_q.gain_loop_enable || !ctrl_q.hold_mode_select) begin
        released_q <= 1'b0;
      end else if (hold_fall && ctrl_q.hold_mode_select) begin
        released_q <= 1'b1;
      end
    end
  end

  // Interval timer: settle wait, then detection interval, in filter ticks.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
    end else if (!ctrl_q.gain_loop_enable || hold) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          st_q <= released_q ? ST_DETECT : ST_SETTLE;
          cnt_q <= 4'h0;
        end
        ST_SETTLE: begin
          if (i_fir_tick) begin
            if (cnt_q == time_q[7:4]) begin
              st_q <= ST_DETECT;
              cnt_q <= 4'h0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        ST_DETECT: begin
          if (i_fir_tick) begin
            if (cnt_q == time_q[3:0]) begin
              cnt_q <= 4'h0;
              st_q <= released_q ? ST_DETECT : ST_SETTLE;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // A measurement is taken at the end of each detection interval.
  assign measure = (st_q == ST_DETECT) & i_fir_tick & (cnt_q == time_q[3:0]) & ~hold;
  assign o_judge_power = meas_q;

  // Power capture, pending result and baseband power readback.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      meas_q <= 8'h00;
      bb_rb_q <= 8'h00;
      ld_pend_q <= 1'b0;
      pend_q <= {rgh_pkg::RGH_GAIN_RST, 1'b0};
    end else begin
      ld_pend_q <= measure;
      if (measure) begin
        meas_q <= i_bb_power;
        if (!released_q) begin
          bb_rb_q <= i_bb_power;
        end
      end
      if (ld_pend_q) begin
        pend_q <= {i_calc_gain, i_calc_wsel};
      end
      if (hold_rise && released_q) begin
        bb_rb_q <= meas_q;
      end
    end
  end

  // Gain and word-select state: applied per interval, or at hold rise.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cur_q <= {rgh_pkg::RGH_GAIN_RST, 1'b0};
    end else if (!ctrl_q.gain_loop_enable) begin
      cur_q.wsel <= 1'b0;
    end else if (hold_rise && released_q) begin
      cur_q <= pend_q;
    end else if (ld_pend_q && !released_q && !hold) begin
      cur_q <= {i_calc_gain, i_calc_wsel};
    end
  end
  assign o_pga_gain = cur_q.gain;

  // Output word: top sixteen bits or the chosen window.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_filter_word <= 16'h0000;
    end else if (cur_q.wsel) begin
      o_filter_word <= i_filter_out[23:8];
    end else begin
      // Window 0 is the top sixteen bits; each step moves the window one bit down.
      o_filter_word <= 16'(i_filter_out >> (5'(rgh_pkg::RGH_DEMOD_W - rgh_pkg::RGH_OUT_W)
        - 5'(ctrl_q.filter_output_window)));
    end
  end

  // Demodulator offset add and gain scaling to a sixteen-bit word.
  assign dsum = i_demod + dcof_q;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      demod16_q <= 16'h0000;
    end else if (i_demod_vld) begin
      demod16_q <= 16'(dsum >> (2'h3 - ctrl_q.demod_gain_select));
    end
  end

  // Log power averaging over 2^n filter-rate samples.
  assign nlim = 8'(8'h01 << ctrl_q.level_average_count);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      acc_q <= 15'h0000;
      nsmp_q <= 7'h00;
      avg_q <= 8'h00;
    end else if (i_fir_tick) begin
      if ({1'b0, nsmp_q} + 8'h01 >= nlim) begin
        avg_q <= 8'((acc_q + 15'(i_chan_power_log)) >> ctrl_q.level_average_count);
        acc_q <= 15'h0000;
        nsmp_q <= 7'h00;
      end else begin
        acc_q <= acc_q + 15'(i_chan_power_log);
        nsmp_q <= nsmp_q + 7'h01;
      end
    end
  end

  // Level correction: offset, gain change (two codes per dB) and attenuator.
  always_comb begin
    lvl_s = 11'(avg_q) + 11'(signed'(lvl_q.level_offset));
    lvl_s = lvl_s - 11'({cur_q.gain, 1'b0});
    if (i_att_active) begin
      lvl_s = lvl_s + 11'(signed'(lvl_q.attenuator_level_correction));
    end
    if (lvl_s < 0) begin
      level_d = 8'h00;
    end else if (lvl_s > 11'sd255) begin
      level_d = 8'hFF;
    end else begin
      level_d = lvl_s[7:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      level_q <= 8'h00;
    end else begin
      level_q <= level_d;
    end
  end

  // Level DAC input with floor and saturation.
  always_comb begin
    ldac = 13'({5'h00, level_q} + {5'h00, lvl_q.dac_manual_value}) << 4;
    lfloor = 13'({lvl_q.dac_level_floor, 4'h0});
    if (ldac <= lfloor) begin
      ldac = lfloor;
    end
    if (ldac >= rgh_pkg::RGH_DAC_MAX) begin
      ldac = rgh_pkg::RGH_DAC_MAX;
    end
  end

  // Detector DAC source select.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      dac_q <= 12'h000;
    end else if (ctrl_q.dac_manual_source) begin
      dac_q <= {lvl_q.dac_manual_value, 4'h0};
    end else if (ctrl_q.dac_level_source) begin
      dac_q <= ldac[11:0];
    end else begin
      dac_q <= demod16_q[15:4];
    end
  end
  assign o_detector_dac = dac_q;

  // Serial frame: demod word then level code, MSB first, bit clock at half rate.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      shift_q <= 24'h00_0000;
      bit_q <= 5'h00;
      sclk_q <= 1'b0;
      frame_q <= 1'b0;
    end else if (i_demod_vld && ctrl_q.rx_interface_select == rgh_pkg::RGH_IF_SERIAL) begin
      shift_q <= {16'(dsum >> (2'h3 - ctrl_q.demod_gain_select)), level_q};
      bit_q <= 5'(rgh_pkg::RGH_FRAME_BITS);
      sclk_q <= 1'b0;
      frame_q <= 1'b1;
    end else if (bit_q != 5'h00) begin
      sclk_q <= ~sclk_q;
      if (sclk_q) begin
        shift_q <= {shift_q[22:0], 1'b0};
        bit_q <= bit_q - 5'h01;
        frame_q <= 1'b0;
      end
    end else begin
      sclk_q <= 1'b0;
    end
  end
  assign o_rx_frame = frame_q;
  assign o_rx_bit_clk = sclk_q;
  assign o_rx_serial_data_pin = shift_q[23];
endmodule : rgh_core

// [core/rgh_pkg.sv]
// Purpose: Shared constants and types for the receive gain-hold and level block.
// Assumes: APB registers are one aligned 32-bit word each.
// Notes: Field positions follow the member order of the packed structs, first member highest.
package rgh_pkg;
  // Register byte offsets.
  localparam logic [7:0] RGH_A_CTRL = 8'h00;
  localparam logic [7:0] RGH_A_TIME = 8'h04;
  localparam logic [7:0] RGH_A_DCOF = 8'h08;
  localparam logic [7:0] RGH_A_LVL = 8'h0C;
  localparam logic [7:0] RGH_A_STAT = 8'h10;
  // Reset values.
  localparam logic [31:0] RGH_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] RGH_TIME_RST = 8'h33;
  localparam logic [5:0] RGH_GAIN_RST = 6'h00;
  // Widths and fixed figures.
  localparam int RGH_DEMOD_W = 24;
  localparam int RGH_OUT_W = 16;
  localparam int RGH_DAC_W = 12;
  localparam int RGH_DROP_LSB = 4;
  localparam int RGH_FRAME_BITS = 24;
  localparam logic [1:0] RGH_IF_SERIAL = 2'h2;
  localparam logic [12:0] RGH_DAC_MAX = 13'h0FFF;
  // Control register image.
  typedef struct packed {
    logic [13:0] spare;
    logic [2:0] filter_output_window;
    logic [2:0] level_average_count;
    logic [1:0] output_rate_divider;
    logic [1:0] demod_gain_select;
    logic [1:0] rx_interface_select;
    logic dac_manual_source;
    logic dac_level_source;
    logic gain_loop_enable;
    logic hold_mode_select;
    logic hold_source_select;
    logic hold_request_bit;
  } rgh_ctrl_t;
  // Level arithmetic settings.
  typedef struct packed {
    logic [7:0] dac_level_floor;
    logic [7:0] dac_manual_value;
    logic [7:0] attenuator_level_correction;
    logic [7:0] level_offset;
  } rgh_lvl_t;
  // Gain loop working state.
  typedef struct packed {
    logic [5:0] gain;
    logic wsel;
  } rgh_gain_t;
endpackage : rgh_pkg

// [sim/rgh_core_assertions.sv]
// Purpose: Port-level assertions for the gain-hold and level block.
// Assumes: Control byte and manual DAC value are mirrored from APB writes.
// Notes: Bound to every rgh_core instance at the foot of this file.
`timescale 1ns/100ps
module rgh_core_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic i_second_squelch_output,
  input wire logic o_gain_hold_pin_out,
  input wire logic o_gain_hold_pin_oe,
  input wire logic i_demod_vld,
  input wire logic [5:0] i_calc_gain,
  input wire logic [7:0] i_bb_power,
  input wire logic [5:0] o_pga_gain,
  input wire logic [7:0] o_judge_power,
  input wire logic [11:0] o_detector_dac,
  input wire logic o_rx_frame
);
  logic [7:0] ctrl_q;
  logic [7:0] man_q;
  logic acc;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Access phase strobe.
  assign acc = psel && penable;
  // Mirrors the control byte and the manual value as software writes them.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= 8'h00;
      man_q <= 8'h00;
    end else if (acc && pwrite && paddr == rgh_pkg::RGH_A_CTRL) begin
      ctrl_q <= pwdata[7:0];
    end else if (acc && pwrite && paddr == rgh_pkg::RGH_A_LVL) begin
      man_q <= pwdata[23:16];
    end
  end
  bus_error_a: assert property (acc |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h10))
    else $error("error response does not match the address map");
  pin_follow_a: assert property (o_gain_hold_pin_out == i_second_squelch_output)
    else $error("shared pin does not carry the squelch level");
  pin_dir_a: assert property (o_gain_hold_pin_oe == ctrl_q[1])
    else $error("shared pin direction does not follow the source select");
  manual_dac_a: assert property (ctrl_q[5] && $past(ctrl_q[5]) && $stable(man_q) |->
    o_detector_dac == {man_q, 4'h0}) else $error("manual value missing on detector DAC");
  hold_freeze_a: assert property (!ctrl_q[2] && ctrl_q[0] && $past(ctrl_q[0]) &&
    $past(ctrl_q[0], 2) |-> $stable(o_pga_gain)) else $error("gain moved while held");
  gain_source_a: assert property (!ctrl_q[2] && $changed(o_pga_gain) |->
    o_pga_gain == $past(i_calc_gain)) else $error("gain not taken from loop result");
  judge_power_a: assert property ($changed(o_judge_power) |->
    o_judge_power == $past(i_bb_power)) else $error("measured power not from input");
  frame_start_a: assert property (ctrl_q[7:6] == rgh_pkg::RGH_IF_SERIAL && i_demod_vld |=>
    o_rx_frame) else $error("serial frame did not start");
endmodule : rgh_core_checker
bind rgh_core rgh_core_checker i_rgh_core_checker (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pslverr(pslverr), .i_second_squelch_output(i_second_squelch_output),
  .o_gain_hold_pin_out(o_gain_hold_pin_out), .o_gain_hold_pin_oe(o_gain_hold_pin_oe),
  .i_demod_vld(i_demod_vld), .i_calc_gain(i_calc_gain), .i_bb_power(i_bb_power),
  .o_pga_gain(o_pga_gain), .o_judge_power(o_judge_power),
  .o_detector_dac(o_detector_dac), .o_rx_frame(o_rx_frame));

// [sim/rgh_host.sv]
// Purpose: Host side of the shared gain-hold pin.
// Assumes: The block drives the pin while its enable is low.
// Notes: The host drives only after the block has turned the pin round.
`timescale 1ns/100ps
module rgh_host (
  input wire logic i_sys_clk,
  input wire logic i_hold_req,
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  output logic o_pin_level
);
  logic hold_q;
  // Hold level changes just after a clock edge, like a host port.
  always_ff @(posedge i_sys_clk) begin
    hold_q <= i_hold_req;
  end
  // Resolved wire level seen by both parties.
  assign o_pin_level = i_pin_oe ? hold_q : i_pin_out;
endmodule : rgh_host

// [sim/test_rx_gain_hold_level_detector.sv]
// Purpose: Self-checking bench for the gain-hold, detector source and level block.
// Assumes: Expectations come from the integer model in this file.
// Notes: Index 0..4 selects control, timing, offset, level and status words.
`timescale 1ns/100ps
module test_rx_gain_hold_level_detector;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, seed = 32'h0000_005B;
  logic sq = 1'b0, hh = 1'b0, pin, pin_out, pin_oe, tick = 1'b0, vld = 1'b0;
  logic att = 1'b0, cw = 1'b0, von = 1'b1, fr, bck, sd;
  logic [7:0] bb = 8'h00, chp = 8'h00, jp;
  logic [5:0] cg = 6'h00, gain;
  logic [23:0] dem = 24'h00_0000, fo = 24'h00_0000;
  logic [15:0] fword;
  logic [11:0] dac;
  logic [7:0] ad[5] = '{rgh_pkg::RGH_A_CTRL, rgh_pkg::RGH_A_TIME, rgh_pkg::RGH_A_DCOF,
    rgh_pkg::RGH_A_LVL, rgh_pkg::RGH_A_STAT};
  logic [31:0] mk[4] = '{32'h0003_FFFF, 32'h0000_00FF, 32'h00FF_FFFF, 32'hFFFF_FFFF};
  int num_errors = 0, n_compared = 0, off, p, o, g1, g2, g3, b, d;
  int mm[3] = '{0, 20, 200};
  int ff[3] = '{0, 250, 0};
  // Free-running clock, 4 ns period.
  always #2 i_sys_clk = ~i_sys_clk;
  // Filter-rate strobe every other cycle; demodulator valid likewise while enabled.
  always @(posedge i_sys_clk) begin
    tick <= ~tick;
    vld <= von & ~vld;
  end
  // Block under test and the host side of the shared hold pin.
  rgh_core i_rgh_core (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_gain_hold_pin(pin), .i_second_squelch_output(sq),
    .o_gain_hold_pin_out(pin_out), .o_gain_hold_pin_oe(pin_oe), .i_fir_tick(tick),
    .i_bb_power(bb), .i_chan_power_log(chp), .i_calc_gain(cg), .i_calc_wsel(cw),
    .i_att_active(att), .i_demod_vld(vld), .i_demod(dem), .i_filter_out(fo),
    .o_pga_gain(gain), .o_filter_word(fword), .o_judge_power(jp), .o_detector_dac(dac),
    .o_rx_frame(fr), .o_rx_bit_clk(bck), .o_rx_serial_data_pin(sd));
  rgh_host i_rgh_host (.i_sys_clk(i_sys_clk), .i_hold_req(hh), .i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .o_pin_level(pin));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Offset added, then shifted by the gain setting and cut to sixteen bits.
  function automatic int scale(int dv, int ov, int g);
    return ((dv + ov) >> (3 - g)) & 65535;
  endfunction : scale
  // Level DAC word with floor and saturation.
  function automatic int lvl_dac(int lev, int m, int f);
    int v;
    v = (lev + m) * 16;
    if (v <= f * 16) v = f * 16;
    if (v >= 4095) v = 4095;
    if (v <= 0) v = 0;
    return v;
  endfunction : lvl_dac
  // One APB transfer; request held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dv;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    @(posedge i_sys_clk);
    while (pready !== 1'b1) @(posedge i_sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wreg(input int a, input logic [31:0] dv);
    apb(1'b1, ad[a], dv);
  endtask : wreg
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Reads a register and compares one field of it.
  task automatic rdf(input int a, input int sh, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, ad[a], 32'h0000_0000);
    chk((rd >> sh) & m, e);
  endtask : rdf
  // Starts one frame with a single valid pulse and collects bits while the bit clock is high.
  task automatic ser_chk(input int e);
    logic [23:0] sv;
    int k;
    int fs;
    sv = 24'h00_0000;
    k = 0;
    fs = 0;
    @(posedge i_sys_clk);
    von <= 1'b1;
    @(posedge i_sys_clk);
    von <= 1'b0;
    repeat (60) begin
      @(posedge i_sys_clk);
      if (fr === 1'b1) fs++;
      if (bck === 1'b1 && k < 24) begin
        sv = {sv[22:0], sd};
        k++;
      end
    end
    chk(sv, e);
    chk(fs, 2);
  endtask : ser_chk
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // Main sequence.
  initial begin
    cyc(2);
    i_rst_n <= 1'b1;
    rdf(0, 0, 32'hFFFF_FFFF, rgh_pkg::RGH_CTRL_RST);
    rdf(1, 0, 32'hFFFF_FFFF, rgh_pkg::RGH_TIME_RST);
    wreg(4, 32'hFFFF_FFFF);
    rdf(4, 0, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      d = xs() & mk[i];
      wreg(i, d);
      rdf(i, 0, 32'hFFFF_FFFF, d);
    end
    $display("test registers done");
    dem <= 24'(xs() & 32'h001F_FFFF);
    off = xs() & 32'h001F_FFFF;
    wreg(2, off);
    for (int g = 0; g < 4; g++) begin
      wreg(0, g << 8);
      cyc(6);
      chk(dac, scale(dem, off, g) >> 4);
    end
    wreg(3, 32'h00A5_0000);
    wreg(0, 32'h0000_0030);
    cyc(4);
    chk(dac, 32'h0000_0A50);
    wreg(0, 32'h0000_0080);
    cyc(8);
    $display("test detector source done");
    p = 60 + xs() % 64;
    o = int'(xs() % 16) - 8;
    chp <= 8'(p);
    att <= 1'b1;
    wreg(0, 32'h0000_2010);
    for (int i = 0; i < 3; i++) begin
      wreg(3, {8'(ff[i]), 8'(mm[i]), 8'h0A, 8'(o)});
      cyc(100);
      rdf(4, 0, 32'h0000_00FF, p + o + 10);
      chk(dac, lvl_dac(p + o + 10, mm[i], ff[i]));
    end
    von <= 1'b0;
    wreg(0, 32'h0000_2090);
    ser_chk((scale(dem, off, 0) << 8) | (p + o + 10));
    $display("test level done");
    wreg(0, 32'h0000_0001);
    rdf(4, 23, 32'h1, 32'h1);
    sq <= 1'b1;
    hh <= 1'b1;
    wreg(0, 32'h0000_0000);
    cyc(4);
    chk({31'h0, pin_oe}, 32'h0);
    chk({31'h0, pin_out}, 32'h1);
    rdf(4, 23, 32'h1, 32'h0);
    wreg(0, 32'h0000_0002);
    cyc(4);
    rdf(4, 23, 32'h1, 32'h1);
    hh <= 1'b0;
    cyc(4);
    rdf(4, 23, 32'h1, 32'h0);
    $display("test hold source done");
    g1 = xs() % 64;
    g2 = g1 ^ 21;
    g3 = g1 ^ 42;
    b = xs() % 256;
    cg <= 6'(g1);
    cw <= 1'b1;
    bb <= 8'(b);
    fo <= 24'(xs());
    wreg(1, 32'h0000_0000);
    wreg(0, 32'h0000_0008);
    cyc(30);
    chk(gain, g1);
    chk(jp, b);
    chk(fword, fo[23:8]);
    cw <= 1'b0;
    wreg(0, 32'h0002_8008);
    cyc(30);
    chk(fword, fo[18:3]);
    wreg(0, 32'h0002_8009);
    cg <= 6'(g2);
    cyc(30);
    chk(gain, g1);
    wreg(0, 32'h0002_8008);
    cyc(30);
    chk(gain, g2);
    wreg(0, 32'h0000_000D);
    wreg(0, 32'h0000_000C);
    cg <= 6'(g3);
    bb <= 8'(b ^ 255);
    cyc(30);
    chk(gain, g2);
    rdf(4, 8, 32'h0000_00FF, b);
    wreg(0, 32'h0000_000D);
    cyc(2);
    chk(gain, g3);
    rdf(4, 8, 32'h0000_00FF, b ^ 255);
    $display("test gain hold done");
    end_sim();
  end
  // Watchdog: the tests take under 5000 cycles, so 25000 cycles means a hang.
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
endmodule : test_rx_gain_hold_level_detector
